// file: core/adcc_pkg.sv
// Constants for the converter configuration control block.
// Assumes a 10 MHz core clock and a host register access port.
package adcc_pkg;
  // ************************************************************
  // Register pointer and layout
  // ************************************************************
  localparam logic [1:0] ADCC_PTR_RESULT = 2'h0;
  localparam logic [1:0] ADCC_PTR_CONFIG = 2'h1;
  localparam logic [1:0] ADCC_PTR_LO_TH = 2'h2;
  localparam logic [1:0] ADCC_PTR_HI_TH = 2'h3;
  localparam int ADCC_CFG_W = 16;
  localparam int ADCC_BIT_START = 15;
  localparam int ADCC_POS_INSEL = 12;
  localparam int ADCC_POS_GAIN = 9;
  localparam int ADCC_BIT_MODE = 8;
  localparam int ADCC_POS_RATE = 5;
  localparam logic [15:0] ADCC_CFG_RESET = 16'h8583;
  localparam logic [2:0] ADCC_INSEL_RST = 3'h0;
  localparam logic [2:0] ADCC_GAIN_RST = 3'h2;
  localparam logic ADCC_MODE_RST = 1'b1;
  localparam logic [2:0] ADCC_RATE_RST = 3'h4;
  localparam logic [4:0] ADCC_COMP_RST = 5'h03;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int ADCC_CLK_HZ = 10_000_000;
  localparam int ADCC_RATE_TAB [8] = '{128, 250, 490, 920, 1600, 2400,
                                       3300, 3300};
  localparam int ADCC_CNT_W = 17;
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_SINGLE = 2'b01,
    ADCC_CONT = 2'b10
  } adcc_state_e;
endpackage

// file: core/adcc_period.sv
// Conversion period lookup: rate code to cycle count.
// Assumes adcc_pkg; purely combinational.
module adcc_period (
  input wire logic [2:0] i_rate,
  output logic [adcc_pkg::ADCC_CNT_W-1:0] o_cycles
);
  import adcc_pkg::*;
  // Longest time per sample, rounded down, never below one cycle
  function automatic logic [ADCC_CNT_W-1:0] cyc(input int sps);
    int c;
    c = ADCC_CLK_HZ / sps;
    if (c < 1) begin
      c = 1;
    end
    return c[ADCC_CNT_W-1:0];
  endfunction
  always_comb begin
    o_cycles = cyc(ADCC_RATE_TAB[i_rate]); // see R07
  end
endmodule // adcc_period

// file: core/adcc_ctrl.sv
// Configuration register bits 15..0 of a 12-bit converter and its
// conversion sequencer. Assumes a host serial front end that
// delivers a pointer write and 16-bit register writes and reads.
//
// Notes on behaviour
// R01 - Writing one to start bit while idle, with mode bit 1, begins exactly one conversion.
// R02 - Start writes are ignored while a conversion is in progress.
// R03 - Start bit reads 0 while converting, 1 otherwise; resets to 1.
// R04 - Three-bit input select, reset 000, picks the measured input pair.
// R05 - Three-bit gain field, reset 010, picks the full-scale range.
// R06 - Mode bit: 0 continuous conversion, 1 single-shot or powered down.
// R07 - Three-bit rate field, reset 100, sets conversion rate; 110/111 same.
// R08 - Host selects this register by writing pointer code 01 first.
// R09 - Register is 16 bits holding mode, input, rate, range, comparator.
// R10 - Single-shot returns to power-down after finishing; start reads 1.
module adcc_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ptr_we,
  input wire logic [1:0] i_ptr,
  input wire logic i_reg_we,
  input wire logic [adcc_pkg::ADCC_CFG_W-1:0] i_reg_wdata,
  output logic [adcc_pkg::ADCC_CFG_W-1:0] o_cfg_rdata,
  output logic o_cfg_sel,
  output logic [2:0] o_input_select,
  output logic [2:0] o_gain_range_select,
  output logic [2:0] o_conversion_rate_select,
  output logic [4:0] o_comp_cfg,
  output logic o_converting,
  output logic o_conv_done
);
  import adcc_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Slowest rate must fit the period counter
  if (ADCC_CLK_HZ / ADCC_RATE_TAB[0] >= (1 << ADCC_CNT_W)) begin : g_cnt_w
    $error("period counter too narrow");
  end
  // Read-back word is built from fixed field slices
  if (ADCC_CFG_W != 16 || ADCC_BIT_START != ADCC_CFG_W - 1) begin : g_cfg_w
    $error("configuration word layout unsupported");
  end
  if (ADCC_POS_INSEL != 12 || ADCC_POS_GAIN != 9 || ADCC_BIT_MODE != 8
      || ADCC_POS_RATE != 5) begin : g_fields
    $error("field positions do not match read-back slices");
  end

  // ************************************************************
  // Pointer
  // ************************************************************
  logic [1:0] ptr;
  logic cfg_wr;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ptr <= ADCC_PTR_RESULT;
    end else if (i_ptr_we) begin
      ptr <= i_ptr;
    end
  end

  assign cfg_wr = i_reg_we && (ptr == ADCC_PTR_CONFIG); // see R08

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cfg_sel <= 1'b0;
    end else begin
      o_cfg_sel <= (i_ptr_we ? i_ptr : ptr) == ADCC_PTR_CONFIG;
    end
  end

  // ************************************************************
  // Configuration fields
  // ************************************************************
  logic mode;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_input_select <= ADCC_INSEL_RST;
    end else if (cfg_wr) begin
      o_input_select <= i_reg_wdata[ADCC_POS_INSEL +: 3]; // see R04
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_gain_range_select <= ADCC_GAIN_RST;
    end else if (cfg_wr) begin
      o_gain_range_select <= i_reg_wdata[ADCC_POS_GAIN +: 3]; // see R05
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode <= ADCC_MODE_RST;
    end else if (cfg_wr) begin
      mode <= i_reg_wdata[ADCC_BIT_MODE]; // see R06
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_conversion_rate_select <= ADCC_RATE_RST;
    end else if (cfg_wr) begin
      o_conversion_rate_select <= i_reg_wdata[ADCC_POS_RATE +: 3]; // see R07
    end
  end

  // Comparator bits are only stored and read back here
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_comp_cfg <= ADCC_COMP_RST;
    end else if (cfg_wr) begin
      o_comp_cfg <= i_reg_wdata[4:0]; // see R09
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  adcc_state_e state;
  adcc_state_e next_state;
  logic [ADCC_CNT_W-1:0] period;
  logic [ADCC_CNT_W-1:0] cnt;
  logic start_req;
  logic last;

  adcc_period u_period (
    .i_rate(o_conversion_rate_select),
    .o_cycles(period)
  );

  // Start only counts from power-down; busy writes drop it
  assign start_req = cfg_wr && i_reg_wdata[ADCC_BIT_START]
                     && (state == ADCC_IDLE); // see R01, R02
  assign last = (cnt + 1'b1) >= period;

  always_comb begin
    next_state = state;
    case (state)
      ADCC_IDLE: begin
        if (cfg_wr && !i_reg_wdata[ADCC_BIT_MODE]) begin
          next_state = ADCC_CONT; // see R06
        end else if (start_req) begin
          next_state = ADCC_SINGLE; // see R01
        end
      end
      ADCC_SINGLE: begin
        if (last) begin
          next_state = mode ? ADCC_IDLE : ADCC_CONT; // see R10
        end
      end
      ADCC_CONT: begin
        // Leaving continuous mode waits for the running sample
        if (last && mode) begin
          next_state = ADCC_IDLE; // see R06
        end
      end
      default: begin
        next_state = ADCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ADCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Rate changes mid-sample take effect at the compare, no restart
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (state == ADCC_IDLE || last) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_converting <= 1'b0;
    end else begin
      o_converting <= next_state != ADCC_IDLE; // see R03
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_conv_done <= 1'b0;
    end else begin
      o_conv_done <= (state != ADCC_IDLE) && last; // see R10
    end
  end

  // ************************************************************
  // Read back
  // ************************************************************
  logic [ADCC_CFG_W-1:0] next_rdata;

  always_comb begin
    next_rdata = {next_state == ADCC_IDLE, // see R03
                  cfg_wr ? i_reg_wdata[14:12] : o_input_select,
                  cfg_wr ? i_reg_wdata[11:9] : o_gain_range_select,
                  cfg_wr ? i_reg_wdata[8] : mode,
                  cfg_wr ? i_reg_wdata[7:5] : o_conversion_rate_select,
                  cfg_wr ? i_reg_wdata[4:0] : o_comp_cfg}; // see R09
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= ADCC_CFG_RESET; // see R03
    end else begin
      o_cfg_rdata <= next_rdata;
    end
  end
endmodule // adcc_ctrl

// file: tb/adcc_properties.sv
// Port assertions of the conversion control block.
// Assumes one clock and a synchronous active-low reset.
module adcc_properties (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ptr_we,
  input wire logic [1:0] i_ptr,
  input wire logic i_reg_we,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_cfg_rdata,
  input wire logic o_cfg_sel,
  input wire logic o_converting,
  input wire logic o_conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire logic wr = o_cfg_sel && i_reg_we;
  // Done cycle excluded as well, though the sequencer is already back in its idle state by then
  wire logic rest = !o_converting && !o_conv_done;
  // Fastest codes: one sample is 3030 cycles of the 10 MHz clock
  localparam logic [11:0] FAST_LEN = 12'hbd6;
  // Cycles of the current sample, 0 on its first converting cycle, its length in the done cycle
  logic [11:0] run;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !o_converting) begin
      run <= 12'h000;
    end else if (o_conv_done) begin
      run <= 12'h001;
    end else if (run != 12'hfff) begin
      run <= run + 12'h001;
    end
  end
  property p_stat; o_cfg_rdata[15] == !o_converting; endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_sel; i_ptr_we |=> o_cfg_sel == ($past(i_ptr) == 2'h1);
  endproperty
  a_sel: assert property (p_sel) else $error("pointer");
  property p_go; wr && i_reg_wdata[15] && rest && o_cfg_rdata[8] |=>
    o_converting; endproperty
  a_go: assert property (p_go) else $error("start");
  property p_nop; wr && !i_reg_wdata[15] && i_reg_wdata[8] && rest |=>
    !o_converting; endproperty
  a_nop: assert property (p_nop) else $error("zero start");
  property p_fld; wr |=> o_cfg_rdata[14:0] == $past(i_reg_wdata[14:0]);
  endproperty
  a_fld: assert property (p_fld) else $error("fields");
  property p_cont; wr && !i_reg_wdata[8] && rest |=> o_converting;
  endproperty
  a_cont: assert property (p_cont) else $error("mode");
  property p_end; $fell(o_converting) |-> o_conv_done; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_len; o_conv_done && o_cfg_rdata[7:6] == 2'h3 |->
    run == FAST_LEN; endproperty
  a_len: assert property (p_len) else $error("period");
  c_go: cover property ($rose(o_converting));
  c_done: cover property (o_conv_done);
  c_cont: cover property (o_converting && !o_cfg_rdata[8]);
endmodule // adcc_properties
bind adcc_ctrl adcc_properties chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_ptr_we(i_ptr_we), .i_ptr(i_ptr), .i_reg_we(i_reg_we),
  .i_reg_wdata(i_reg_wdata), .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_sel(o_cfg_sel), .o_converting(o_converting),
  .o_conv_done(o_conv_done));

// file: tb/adcc_host.sv
// Host master model: pointer load, then one register write.
// Assumes each call is entered just after a clock edge.
module adcc_host (
  input wire logic i_mclk,
  output logic o_ptr_we,
  output logic [1:0] o_ptr,
  output logic o_reg_we,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_ptr_we, o_ptr, o_reg_we, o_wdata} = '0;
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    o_ptr_we <= 1'b1;
    o_ptr <= p;
    @(posedge i_mclk);
    o_ptr_we <= 1'b0;
    o_reg_we <= 1'b1;
    o_wdata <= d;
    @(posedge i_mclk);
    o_reg_we <= 1'b0;
    // Stale data is inverted, never left looking valid
    o_wdata <= ~d;
  endtask
endmodule // adcc_host

// file: tb/adcc_ctrl_test.sv
// Self-checking bench of the conversion control block.
// Assumes the host model and the bound port checker.
module adcc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic look = 1'b0;
  logic pwe, rwe, sel, busy, done;
  logic [1:0] ptr;
  wire logic [13:0] fld;
  logic [15:0] wd, rd, w, e;
  logic [15:0] expq [$];
  int failures = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  adcc_host host (.i_mclk(clk), .o_ptr_we(pwe), .o_ptr(ptr),
    .o_reg_we(rwe), .o_wdata(wd));
  adcc_ctrl uut (.i_mclk(clk), .i_rst_n(rst_n), .i_ptr_we(pwe),
    .i_ptr(ptr), .i_reg_we(rwe), .i_reg_wdata(wd), .o_cfg_rdata(rd),
    .o_cfg_sel(sel), .o_input_select(fld[13:11]),
    .o_gain_range_select(fld[10:8]), .o_conversion_rate_select(fld[7:5]),
    .o_comp_cfg(fld[4:0]), .o_converting(busy), .o_conv_done(done));
  task automatic chk(input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %0t exp %h got %h", $time, x, g);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Oldest note first; an empty queue forces a mismatch
  always @(posedge clk) if (look || done) begin
    e = expq.size() > 0 ? expq.pop_front() : ~rd;
    chk(e, rd);
    chk({2'h0, e[14:9], e[7:0]}, {2'h0, fld});
    chk({15'h0, !e[15]}, {15'h0, busy});
  end
  task automatic peek(input logic [15:0] x);
    expq.push_back(x);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
    @(posedge clk);
  endtask
  task automatic await(input logic [15:0] x);
    expq.push_back(x);
    for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge clk);
    if (done !== 1'b1) begin
      failures++;
      complete_run();
    end else begin
      @(posedge clk);
    end
  endtask
  initial begin
    void'($urandom(32'h4cad0e23));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    peek(16'h8583);
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      w[7:5] = {2'h3, i[0]};
      w[15] = i < 2;
      w[8] = i < 2;
      host.wr(2'h1, w);
      peek({1'b0, w[14:0]});
      host.wr(2'h1, {1'b1, w[14:0]});
      if (i >= 2) begin
        await({1'b0, w[14:0]});
        host.wr(2'h1, w | 16'h0100);
      end
      await(w | 16'h8100);
    end
    host.wr(2'h0, 16'hffff);
    peek(w | 16'h8100);
    w[15] = 1'b0;
    host.wr(2'h1, w | 16'h0100);
    peek(w | 16'h8100);
    complete_run();
  end
endmodule // adcc_ctrl_test
